//--- src/sbs_pkg.sv
// Constants shared by the slip buffer status block.
package sbs_pkg;

    // =====================================================================
    // Bus and register map
    localparam int unsigned SBS_ADDR_W = 8;
    localparam int unsigned SBS_DATA_W = 32;
    localparam logic [7:0] SBS_OFS_EVENT_STATUS = 8'h00;
    localparam logic [7:0] SBS_OFS_EVENT_ENABLE = 8'h04;
    localparam logic [7:0] SBS_OFS_LEVEL = 8'h08;

    // =====================================================================
    // Field positions of slip_buffer_event_status
    localparam int unsigned SBS_BIT_TX_OVERFLOW = 7;
    localparam int unsigned SBS_BIT_TX_UNDERFLOW = 6;
    localparam int unsigned SBS_BIT_TX_SLIP = 5;
    localparam int unsigned SBS_BIT_CARRIER_LOCK = 4;
    localparam int unsigned SBS_BIT_MFRAME_LOCK = 3;
    localparam int unsigned SBS_BIT_RX_OVERFLOW = 2;
    localparam int unsigned SBS_BIT_RX_UNDERFLOW = 1;
    localparam int unsigned SBS_BIT_RX_SLIP = 0;

    // Bits that are sticky clear_on_read event flags; the rest are live.
    localparam logic [7:0] SBS_EVENT_MASK = 8'he7;

    // =====================================================================
    // Reset values
    localparam logic [7:0] SBS_RST_STATUS = 8'h00;
    localparam logic [7:0] SBS_RST_ENABLE = 8'h00;
    localparam logic [31:0] SBS_RST_RDATA = 32'h0000_0000;

    // =====================================================================
    // Slip buffer geometry, in words (one word per channel timeslot).
    localparam int unsigned SBS_LEVEL_W = 7;
    localparam logic [6:0] SBS_FRAME_WORDS = 7'h18;
    localparam logic [6:0] SBS_DEPTH_WORDS = 7'h30;
    localparam logic [6:0] SBS_RST_LEVEL = 7'h18;

endpackage

//--- src/sbs_slip_tracker.sv
// Fill level tracker of one slip buffer with frame drop and frame repeat.
`timescale 1ns/1ns

module sbs_slip_tracker
    import sbs_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Buffer traffic strobes.
    input wire logic wr,
    input wire logic rd,
    // Level and slip events.
    output logic [SBS_LEVEL_W-1:0] level,
    output logic overflow,
    output logic underflow
);

    logic [SBS_LEVEL_W-1:0] level_ff;
    logic [SBS_LEVEL_W-1:0] nxt_level;
    logic overflow_ff;
    logic nxt_overflow;
    logic underflow_ff;
    logic nxt_underflow;

    // =====================================================================
    // Level update
    // A write into a full buffer deletes one whole frame and keeps the new
    // word; a read from an empty buffer replays one whole frame. A write
    // and read in the same cycle pass through and leave the level alone.
    always_comb
    begin
        nxt_level = level_ff;
        nxt_overflow = 1'b0;
        nxt_underflow = 1'b0;
        if (wr && !rd)
        begin
            if (level_ff == SBS_DEPTH_WORDS)
            begin
                nxt_level = SBS_DEPTH_WORDS - SBS_FRAME_WORDS + 7'h01;
                nxt_overflow = 1'b1;
            end
            else
            begin
                nxt_level = level_ff + 7'h01;
            end
        end
        else if (rd && !wr)
        begin
            if (level_ff == 7'h00)
            begin
                nxt_level = SBS_FRAME_WORDS - 7'h01;
                nxt_underflow = 1'b1;
            end
            else
            begin
                nxt_level = level_ff - 7'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level_ff <= SBS_RST_LEVEL;
            overflow_ff <= 1'b0;
            underflow_ff <= 1'b0;
        end
        else
        begin
            level_ff <= nxt_level;
            overflow_ff <= nxt_overflow;
            underflow_ff <= nxt_underflow;
        end
    end

    assign level = level_ff;
    assign overflow = overflow_ff;
    assign underflow = underflow_ff;

endmodule

//--- src/sbs_slip_status.sv
// Slip buffer event status, lock indicators and APB register slave.
`timescale 1ns/1ns

module sbs_slip_status
    import sbs_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_N,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [sbs_pkg::SBS_ADDR_W-1:0] PADDR,
    input wire logic [sbs_pkg::SBS_DATA_W-1:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [sbs_pkg::SBS_DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Slip buffer traffic from the framer timing.
    input wire logic TX_BUF_WR,
    input wire logic TX_BUF_RD,
    input wire logic RX_BUF_WR,
    input wire logic RX_BUF_RD,
    // Receive framer lock indicators.
    input wire logic CARRIER_SUPERFRAME_LOCK,
    input wire logic MULTIFRAME_LOCK,
    // Interrupt request.
    output logic IRQ
);

    import sbs_pkg::*;

    logic [SBS_LEVEL_W-1:0] tx_level;
    logic [SBS_LEVEL_W-1:0] rx_level;
    logic tx_ovf;
    logic tx_udf;
    logic rx_ovf;
    logic rx_udf;

    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;
    logic [7:0] enable_ff;
    logic [7:0] nxt_enable;
    logic [7:0] reported_ff;
    logic [7:0] nxt_reported;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic ready_ff;
    logic nxt_ready;
    logic slverr_ff;
    logic nxt_slverr;
    logic irq_ff;
    logic nxt_irq;

    logic setup;
    logic access_done;
    logic status_clear;
    logic enable_write;
    logic [7:0] set_events;
    logic [7:0] status_view;

    function automatic logic mapped(input logic [SBS_ADDR_W-1:0] addr);
        mapped = (addr == SBS_OFS_EVENT_STATUS) || (addr == SBS_OFS_EVENT_ENABLE)
            || (addr == SBS_OFS_LEVEL);
    endfunction

    // =====================================================================
    // Slip buffer trackers
    sbs_slip_tracker u_tx_tracker
    (
        .clk(CLK),
        .rst_n(RST_N),
        .wr(TX_BUF_WR),
        .rd(TX_BUF_RD),
        .level(tx_level),
        .overflow(tx_ovf),
        .underflow(tx_udf)
    );

    sbs_slip_tracker u_rx_tracker
    (
        .clk(CLK),
        .rst_n(RST_N),
        .wr(RX_BUF_WR),
        .rd(RX_BUF_RD),
        .level(rx_level),
        .overflow(rx_ovf),
        .underflow(rx_udf)
    );

    // =====================================================================
    // APB phase decode
    // Side effects of a transfer key off the edge on which the slave is
    // ready, never off the setup edge, so an abandoned setup changes nothing.
    always_comb
    begin
        setup = PSEL && !PENABLE;
        access_done = PSEL && PENABLE && ready_ff;
        status_clear = access_done && !PWRITE && (PADDR == SBS_OFS_EVENT_STATUS);
        enable_write = access_done && PWRITE && PSTRB[0] && (PADDR == SBS_OFS_EVENT_ENABLE);
    end

    // =====================================================================
    // Event flags
    // The read data is captured in the setup cycle, so only the flags that
    // were actually returned are cleared at the access edge; an event that
    // lands in between, or in the clearing cycle itself, is kept.
    always_comb
    begin
        set_events = 8'h00;
        set_events[SBS_BIT_TX_OVERFLOW] = tx_ovf;
        set_events[SBS_BIT_TX_UNDERFLOW] = tx_udf;
        set_events[SBS_BIT_TX_SLIP] = tx_ovf || tx_udf;
        set_events[SBS_BIT_RX_OVERFLOW] = rx_ovf;
        set_events[SBS_BIT_RX_UNDERFLOW] = rx_udf;
        set_events[SBS_BIT_RX_SLIP] = rx_ovf || rx_udf;
        nxt_flags = flags_ff;
        if (status_clear)
        begin
            nxt_flags = flags_ff & ~reported_ff;
        end
        nxt_flags = (nxt_flags | set_events) & SBS_EVENT_MASK;
        status_view = flags_ff;
        status_view[SBS_BIT_CARRIER_LOCK] = CARRIER_SUPERFRAME_LOCK;
        status_view[SBS_BIT_MFRAME_LOCK] = MULTIFRAME_LOCK;
    end

    // =====================================================================
    // Interrupt request
    // Only enabled event flags raise the request; it follows the flags one
    // clock later and drops one clock after the clearing read.
    always_comb
    begin
        nxt_irq = |(flags_ff & enable_ff);
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_ff <= nxt_irq;
        end
    end

    // =====================================================================
    // APB access
    // Answers are prepared on the setup edge, so PREADY is high in the
    // first access cycle and every transfer takes exactly two cycles.
    always_comb
    begin
        nxt_enable = enable_ff;
        nxt_rdata = rdata_ff;
        nxt_reported = reported_ff;
        nxt_ready = setup;
        nxt_slverr = 1'b0;
        if (setup)
        begin
            nxt_rdata = SBS_RST_RDATA;
            nxt_reported = 8'h00;
            nxt_slverr = !mapped(PADDR);
            if (!PWRITE)
            begin
                case (PADDR)
                    SBS_OFS_EVENT_STATUS:
                    begin
                        nxt_rdata[7:0] = status_view;
                        nxt_reported = status_view & SBS_EVENT_MASK;
                    end
                    SBS_OFS_EVENT_ENABLE: nxt_rdata[7:0] = enable_ff;
                    SBS_OFS_LEVEL:
                    begin
                        nxt_rdata[SBS_LEVEL_W-1:0] = tx_level;
                        nxt_rdata[8+SBS_LEVEL_W-1:8] = rx_level;
                    end
                    default: nxt_rdata = SBS_RST_RDATA;
                endcase
            end
        end
        if (enable_write)
        begin
            nxt_enable = PWDATA[7:0] & SBS_EVENT_MASK;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            flags_ff <= SBS_RST_STATUS;
            enable_ff <= SBS_RST_ENABLE;
            reported_ff <= SBS_RST_STATUS;
            rdata_ff <= SBS_RST_RDATA;
            ready_ff <= 1'b0;
            slverr_ff <= 1'b0;
        end
        else
        begin
            flags_ff <= nxt_flags;
            enable_ff <= nxt_enable;
            reported_ff <= nxt_reported;
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            slverr_ff <= nxt_slverr;
        end
    end

    assign PRDATA = rdata_ff;
    assign PREADY = ready_ff;
    assign PSLVERR = slverr_ff;
    assign IRQ = irq_ff;

endmodule

//--- tb/sbs_slip_status_checker.sv
// Port assertions for the slip buffer status block.
`timescale 1ns/1ns
module sbs_slip_status_checker
    import sbs_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_N,
    // APB.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [sbs_pkg::SBS_ADDR_W-1:0] PADDR,
    input wire logic [sbs_pkg::SBS_DATA_W-1:0] PRDATA,
    input wire logic PREADY,
    // Status.
    input wire logic CARRIER_SUPERFRAME_LOCK,
    input wire logic MULTIFRAME_LOCK,
    input wire logic IRQ
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    sequence s_setup; PSEL && !PENABLE; endsequence
    sequence s_rd; s_setup ##0 !PWRITE && PADDR == SBS_OFS_EVENT_STATUS; endsequence
    property p_ready; s_setup |=> PREADY ##1 !PREADY; endproperty
    property p_rst; $rose(RST_N) |-> PRDATA == '0 && !PREADY && !IRQ; endproperty
    property p_txf; s_rd ##1 PRDATA[7] |-> PRDATA[5]; endproperty
    property p_txe; s_rd ##1 PRDATA[6] |-> PRDATA[5]; endproperty
    property p_rxf; s_rd ##1 PRDATA[2] |-> PRDATA[0]; endproperty
    property p_rxe; s_rd ##1 PRDATA[1] |-> PRDATA[0]; endproperty
    property p_lk4;
        s_rd ##0 $stable(CARRIER_SUPERFRAME_LOCK) |=> PRDATA[4] == $past(CARRIER_SUPERFRAME_LOCK);
    endproperty
    property p_lk3;
        s_rd ##0 $stable(MULTIFRAME_LOCK) |=> PRDATA[3] == $past(MULTIFRAME_LOCK);
    endproperty
    a_ready: assert property (p_ready) else $error("Bad ready pulse.");
    a_rst: assert property (p_rst) else $error("Bad reset value.");
    a_txf: assert property (p_txf) else $error("Tx full without slip.");
    a_txe: assert property (p_txe) else $error("Tx empty without slip.");
    a_rxf: assert property (p_rxf) else $error("Rx full without slip.");
    a_rxe: assert property (p_rxe) else $error("Rx empty without slip.");
    a_lk4: assert property (p_lk4) else $error("Carrier lock bit wrong.");
    a_lk3: assert property (p_lk3) else $error("Multiframe lock bit wrong.");
endmodule
bind sbs_slip_status sbs_slip_status_checker sbs_slip_status_checker_inst (.CLK, .RST_N,
    .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .CARRIER_SUPERFRAME_LOCK,
    .MULTIFRAME_LOCK, .IRQ);

//--- tb/sbs_framer_model.sv
// Framer timing model driving slip buffer strobes.
`timescale 1ns/1ns
module sbs_framer_model (
    // Control.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic slow,
    input wire logic [1:0] kind,
    input wire logic [6:0] n,
    // Strobes.
    output logic [3:0] stb,
    output logic busy
);
    logic [6:0] cnt;
    logic [1:0] k;
    logic ph;
    assign busy = cnt != 7'h00;
    // Slow mode leaves an idle cycle between words.
    assign stb = (busy && !(slow && ph)) ? 4'h1 << k : 4'h0;
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            {cnt, k, ph} <= '0;
        else if (go)
            {cnt, k, ph} <= {n, kind, 1'b0};
        else if (busy)
            {cnt, ph} <= {cnt - 7'(stb != 4'h0), ~ph};
endmodule

//--- tb/testbench.sv
// Self-checking bench for the slip buffer status block.
`timescale 1ns/1ns
module testbench;
    import sbs_pkg::*;
    logic CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
    logic go, slow, busy, er, lock_c, lock_m;
    logic [1:0] kind;
    logic [3:0] stb;
    logic [6:0] n;
    logic [7:0] PADDR, fl, en;
    logic [31:0] PWDATA, PRDATA, rd;
    int bad_count = 0;
    int n_compared = 0;
    int lvl[2];
    int i, c;
    sbs_slip_status sbs_slip_status_inst (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .PSTRB(4'h1), .PRDATA, .PREADY, .PSLVERR, .TX_BUF_WR(stb[0]),
        .TX_BUF_RD(stb[1]), .RX_BUF_WR(stb[2]), .RX_BUF_RD(stb[3]),
        .CARRIER_SUPERFRAME_LOCK(lock_c), .MULTIFRAME_LOCK(lock_m), .IRQ);
    sbs_framer_model sbs_framer_model_inst (.clk(CLK), .rst_n(RST_N), .go, .slow, .kind,
        .n, .stb, .busy);
    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    task automatic wrap_up;
        if (bad_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic hang;
        bad_count++;
        wrap_up();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t irq got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_err(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t slverr got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        t = 0;
        do
        begin
            @(posedge CLK);
            t++;
        end
        while (PREADY !== 1'b1 && t < 20);
        if (PREADY !== 1'b1)
            hang();
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // Reference model of one slip buffer word.
    function automatic void step(input int kd);
        int b;
        b = kd / 2;
        if (kd % 2 == 0 && lvl[b] == int'(SBS_DEPTH_WORDS))
        begin
            lvl[b] = lvl[b] - int'(SBS_FRAME_WORDS) + 1;
            fl = fl | (b == 1 ? 8'h05 : 8'ha0);
        end
        else if (kd % 2 == 1 && lvl[b] == 0)
        begin
            lvl[b] = int'(SBS_FRAME_WORDS) - 1;
            fl = fl | (b == 1 ? 8'h03 : 8'h60);
        end
        else
            lvl[b] = lvl[b] + (kd % 2 == 0 ? 1 : -1);
    endfunction
    task automatic burst(input int kd, input int cnt);
        int t;
        @(posedge CLK);
        kind <= 2'(kd);
        n <= 7'(cnt);
        go <= 1'b1;
        @(posedge CLK);
        go <= 1'b0;
        t = 0;
        do
        begin
            @(posedge CLK);
            t++;
        end
        while (busy && t < 200);
        if (busy !== 1'b0)
            hang();
        for (t = 0; t < cnt; t++)
            step(kd);
    endtask
    initial
    begin
        RST_N = 1'b0;
        {PSEL, PENABLE, PWRITE, go, slow, lock_c, lock_m} = '0;
        {PADDR, PWDATA, kind, n, fl} = '0;
        lvl = '{int'(SBS_RST_LEVEL), int'(SBS_RST_LEVEL)};
        c = $urandom(32'hdaa1);
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        apb(1'b0, SBS_OFS_EVENT_ENABLE, '0);
        chk(rd, 32'(SBS_RST_ENABLE));
        apb(1'b0, SBS_OFS_EVENT_STATUS, '0);
        chk(rd, 32'(SBS_RST_STATUS));
        for (i = 0; i < 16; i++)
        begin
            en = 8'($urandom) & SBS_EVENT_MASK;
            apb(1'b1, SBS_OFS_EVENT_ENABLE, 32'(en));
            lock_c <= 1'($urandom);
            lock_m <= 1'($urandom);
            slow <= i[0];
            burst(i % 4, 24 + $urandom % 26);
            repeat (4) @(posedge CLK);
            chk_irq(IRQ, (fl & en) != 8'h00);
            apb(1'b0, SBS_OFS_EVENT_STATUS, '0);
            chk(rd, {24'h0, fl | {3'h0, lock_c, lock_m, 3'h0}});
            fl = 8'h00;
            apb(1'b0, SBS_OFS_LEVEL, '0);
            chk(rd, 32'(lvl[1] * 256 + lvl[0]));
            chk_err(er, 1'b0);
        end
        burst(0, 49);
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        fl = 8'h00;
        lvl = '{int'(SBS_RST_LEVEL), int'(SBS_RST_LEVEL)};
        apb(1'b0, SBS_OFS_EVENT_ENABLE, '0);
        chk(rd, 32'(SBS_RST_ENABLE));
        chk_irq(IRQ, 1'b0);
        apb(1'b0, SBS_OFS_LEVEL, '0);
        chk(rd, 32'(lvl[1] * 256 + lvl[0]));
        apb(1'b0, SBS_OFS_EVENT_STATUS, '0);
        chk(rd, {27'h0, lock_c, lock_m, 3'h0});
        apb(1'b0, 8'hfc, '0);
        chk(rd, 32'h0);
        chk_err(er, 1'b1);
        wrap_up();
    end
endmodule
